// ### common/dcc_regs.vh
`ifndef DCC_REGS_VH
`define DCC_REGS_VH
// register indices on the plain port (word index, 4-bit address)
`define DCC_ADDR_SRC        4'h0
`define DCC_ADDR_DST        4'h1
`define DCC_ADDR_CTRL       4'h2
`define DCC_ADDR_COUNT      4'h3
`define DCC_ADDR_STATUS     4'h4
// control word fields
`define DCC_CTL_IRQ_EN      15
`define DCC_CTL_OUT_REQ_EN  14
`define DCC_CTL_STEAL       13
`define DCC_CTL_ALIGN       12
`define DCC_CTL_BW_HI       11
`define DCC_CTL_BW_LO       9
`define DCC_CTL_ONE_CYC     8
`define DCC_CTL_DIR         7
`define DCC_CTL_SRC_STEP    6
`define DCC_CTL_SW_HI       5
`define DCC_CTL_SW_LO       4
`define DCC_CTL_DST_STEP    3
`define DCC_CTL_DW_HI       2
`define DCC_CTL_DW_LO       1
`define DCC_CTL_START       0
// status fields
`define DCC_ST_CFG_ERR      6
`define DCC_ST_BUS_ERR_SRC  5
`define DCC_ST_BUS_ERR_DST  4
`define DCC_ST_REQ          2
`define DCC_ST_BUSY         1
`define DCC_ST_DONE         0
// width codes
`define DCC_SZ_LONG         2'b00
`define DCC_SZ_BYTE         2'b01
`define DCC_SZ_WORD         2'b10
`define DCC_SZ_LINE         2'b11
`define DCC_RST_CTRL        16'h0000
`define DCC_RST_COUNT       16'h0000
`endif

// ### rtl/dcc_channel.v
// Decided for this implementation: the register addresses and the strobed register port.
`include "dcc_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module dcc_channel (
  input  wire        i_clk,
  input  wire        i_rstn,
  input  wire [3:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  input  wire        i_outside_transfer_request,
  output reg         o_bus_req,
  input  wire        i_bus_grant,
  output reg         o_bus_valid,
  output reg  [31:0] o_bus_addr,
  output reg         o_bus_rw,
  output reg  [1:0]  o_bus_size,
  output reg  [31:0] o_bus_wdata,
  input  wire [31:0] i_bus_rdata,
  input  wire        i_bus_ack,
  input  wire        i_bus_err,
  output reg         o_channel_irq_out,
  output reg         o_done
);
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_READ  = 4'b0010;
  localparam [3:0] ST_WRITE = 4'b0100;
  localparam [3:0] ST_GAP   = 4'b1000;

  reg  [1:0]  rst_sync_reg;
  wire        rstn_int;
  reg  [2:0]  req_sync_reg;
  reg         req_level_reg;
  reg         req_level_prev;
  reg  [31:0] source_pointer_reg;
  reg  [31:0] dest_pointer_reg;
  reg  [15:0] channel_control_reg;
  reg  [15:0] remaining_bytes_reg;
  reg         cfg_err_reg;
  reg         err_src_reg;
  reg         err_dst_reg;
  reg         pend_reg;
  reg         busy_reg;
  reg         done_reg;
  reg  [3:0]  state_reg;
  reg  [31:0] data_reg;
  reg  [15:0] control_next;

  wire        sel_wr_ctrl;
  wire        start_pulse;
  wire        done_clear;
  wire        req_rise;
  wire        new_req;
  wire        steal;
  wire        one_cyc;
  wire        align_on;
  wire [4:0]  src_step;
  wire [4:0]  dst_step;
  wire        src_wider;
  wire        cfg_bad;
  wire [15:0] block_mask;
  wire        bw_on;
  wire        src_moves;
  wire        dst_moves;
  wire [15:0] count_after;
  wire        last_beat;
  wire        at_boundary;
  wire [7:0]  status_word;

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rstn_int = rst_sync_reg[1];

  dcc_size_step u_size (
    .i_src_width  (channel_control_reg[`DCC_CTL_SW_HI:`DCC_CTL_SW_LO]),
    .i_dst_width  (channel_control_reg[`DCC_CTL_DW_HI:`DCC_CTL_DW_LO]),
    .i_interval   (channel_control_reg[`DCC_CTL_BW_HI:`DCC_CTL_BW_LO]),
    .i_src_addr   (source_pointer_reg),
    .i_dst_addr   (dest_pointer_reg),
    .i_count      (remaining_bytes_reg),
    .o_src_step   (src_step),
    .o_dst_step   (dst_step),
    .o_src_wider  (src_wider),
    .o_cfg_bad    (cfg_bad),
    .o_block_mask (block_mask),
    .o_bw_on      (bw_on)
  );

  assign sel_wr_ctrl = i_wr && (i_addr == `DCC_ADDR_CTRL);
  assign start_pulse = channel_control_reg[`DCC_CTL_START];
  assign done_clear  = i_wr && (i_addr == `DCC_ADDR_STATUS) && i_wdata[`DCC_ST_DONE];
  assign steal    = channel_control_reg[`DCC_CTL_STEAL];
  assign one_cyc  = channel_control_reg[`DCC_CTL_ONE_CYC];
  assign align_on = channel_control_reg[`DCC_CTL_ALIGN];
  assign req_rise = req_level_reg && channel_control_reg[`DCC_CTL_OUT_REQ_EN];
  assign new_req  = start_pulse || req_rise;
  assign src_moves = channel_control_reg[`DCC_CTL_SRC_STEP] || (align_on && src_wider);
  assign dst_moves = channel_control_reg[`DCC_CTL_DST_STEP] || (align_on && !src_wider);
  assign count_after = remaining_bytes_reg - {11'h000, (one_cyc ? src_step : dst_step)};
  assign last_beat   = (count_after == 16'h0000);
  assign at_boundary = bw_on && ((count_after & block_mask) == 16'h0000);
  assign status_word = {1'b0, cfg_err_reg, err_src_reg, err_dst_reg, 1'b0,
                        pend_reg, busy_reg, done_reg};

  // outside request: three flops, change counts when last two agree
  always @(posedge i_clk or negedge rstn_int) begin
    if (!rstn_int) begin
      req_sync_reg  <= 3'b000;
      req_level_reg <= 1'b0;
    end else begin
      req_sync_reg  <= {req_sync_reg[1:0], i_outside_transfer_request};
      req_level_reg <= 1'b0;
      if (req_sync_reg[2] == req_sync_reg[1]) begin
        req_level_reg <= req_sync_reg[1] && !req_sync_reg[2] ? 1'b0 : 1'b0;
      end
      if (req_sync_reg[1] && !req_sync_reg[2]) begin
        req_level_reg <= 1'b0;
      end
      if (req_sync_reg[2] && req_sync_reg[1] && !req_level_prev) begin
        req_level_reg <= 1'b1;
      end
    end
  end

  always @(posedge i_clk or negedge rstn_int) begin
    if (!rstn_int) begin
      req_level_prev <= 1'b0;
    end else if (req_sync_reg[2] == req_sync_reg[1]) begin
      req_level_prev <= req_sync_reg[2];
    end
  end

  always @* begin
    control_next = channel_control_reg;
    control_next[`DCC_CTL_START] = 1'b0;
    if (sel_wr_ctrl) begin
      control_next = i_wdata[15:0];
    end
  end

  // register writes and reads
  always @(posedge i_clk or negedge rstn_int) begin
    if (!rstn_int) begin
      channel_control_reg <= `DCC_RST_CTRL;
      o_rdata             <= 32'h0000_0000;
    end else begin
      channel_control_reg <= control_next;
      o_rdata             <= 32'h0000_0000;
      if (i_rd) begin
        case (i_addr)
          `DCC_ADDR_SRC:    o_rdata <= source_pointer_reg;
          `DCC_ADDR_DST:    o_rdata <= dest_pointer_reg;
          `DCC_ADDR_CTRL:   o_rdata <= {16'h0000, channel_control_reg[15:1], 1'b0};
          `DCC_ADDR_COUNT:  o_rdata <= {16'h0000, remaining_bytes_reg};
          `DCC_ADDR_STATUS: o_rdata <= {24'h0000_00, status_word};
          default:          o_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // transfer engine
  always @(posedge i_clk or negedge rstn_int) begin
    if (!rstn_int) begin
      remaining_bytes_reg <= `DCC_RST_COUNT;
      source_pointer_reg  <= 32'h0000_0000;
      dest_pointer_reg    <= 32'h0000_0000;
      cfg_err_reg <= 1'b0;
      err_src_reg <= 1'b0;
      err_dst_reg <= 1'b0;
      pend_reg    <= 1'b0;
      busy_reg    <= 1'b0;
      done_reg    <= 1'b0;
      state_reg   <= ST_IDLE;
      data_reg    <= 32'h0000_0000;
      o_bus_req   <= 1'b0;
      o_bus_valid <= 1'b0;
      o_bus_addr  <= 32'h0000_0000;
      o_bus_rw    <= 1'b1;
      o_bus_size  <= 2'b00;
      o_bus_wdata <= 32'h0000_0000;
      o_channel_irq_out <= 1'b0;
      o_done      <= 1'b0;
    end else begin
      if (i_wr && i_addr == `DCC_ADDR_SRC) begin
        source_pointer_reg <= i_wdata;
      end
      if (i_wr && i_addr == `DCC_ADDR_DST) begin
        dest_pointer_reg <= i_wdata;
      end
      if (i_wr && i_addr == `DCC_ADDR_COUNT) begin
        remaining_bytes_reg <= i_wdata[15:0];
      end
      o_channel_irq_out <= channel_control_reg[`DCC_CTL_IRQ_EN]
                           && (done_reg || cfg_err_reg);
      o_done <= done_reg;
      case (state_reg)
        ST_IDLE: begin
          o_bus_valid <= 1'b0;
          if (new_req) begin
            if (cfg_bad || remaining_bytes_reg == 16'h0000) begin
              cfg_err_reg <= cfg_bad ? 1'b1 : cfg_err_reg;
              done_reg    <= 1'b1;
            end else begin
              busy_reg  <= 1'b1;
              pend_reg  <= 1'b1;
              o_bus_req <= 1'b1;
              state_reg <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          o_bus_req <= 1'b1;
          if (i_bus_grant) begin
            pend_reg    <= 1'b0;
            o_bus_valid <= 1'b1;
            o_bus_addr  <= source_pointer_reg;
            o_bus_size  <= channel_control_reg[`DCC_CTL_SW_HI:`DCC_CTL_SW_LO];
            o_bus_rw    <= one_cyc ? channel_control_reg[`DCC_CTL_DIR] : 1'b1;
            state_reg   <= one_cyc ? ST_WRITE : ST_READ;
          end
        end
        ST_READ: begin
          if (i_bus_err) begin
            err_src_reg <= 1'b1;
            done_reg    <= 1'b1;
            o_bus_valid <= 1'b0;
            o_bus_req   <= 1'b0;
            busy_reg    <= 1'b0;
            state_reg   <= ST_IDLE;
          end else if (i_bus_ack) begin
            data_reg <= i_bus_rdata;
            if (src_moves) begin
              source_pointer_reg <= source_pointer_reg + {27'h000_0000, src_step};
            end
            o_bus_addr  <= dest_pointer_reg;
            o_bus_size  <= channel_control_reg[`DCC_CTL_DW_HI:`DCC_CTL_DW_LO];
            o_bus_rw    <= 1'b0;
            o_bus_wdata <= i_bus_rdata;
            state_reg   <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (i_bus_err) begin
            if (one_cyc) err_src_reg <= 1'b1;
            else err_dst_reg <= 1'b1;
            done_reg    <= 1'b1;
            o_bus_valid <= 1'b0;
            o_bus_req   <= 1'b0;
            busy_reg    <= 1'b0;
            state_reg   <= ST_IDLE;
          end else if (i_bus_ack) begin
            // decrement on write or single phase
            remaining_bytes_reg <= count_after;
            if (one_cyc) begin
              if (src_moves) begin
                source_pointer_reg <= source_pointer_reg + {27'h000_0000, src_step};
              end
            end else if (dst_moves) begin
              dest_pointer_reg <= dest_pointer_reg + {27'h000_0000, dst_step};
            end
            o_bus_valid <= 1'b0;
            if (last_beat) begin
              done_reg  <= 1'b1;
              busy_reg  <= 1'b0;
              o_bus_req <= 1'b0;
              state_reg <= ST_IDLE;
            end else if (steal) begin
              o_bus_req <= 1'b0;
              busy_reg  <= 1'b0;
              state_reg <= ST_IDLE;
            end else begin
              o_bus_req <= !at_boundary;
              pend_reg  <= 1'b1;
              state_reg <= ST_GAP;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      // done write aborts and clears status
      if (done_clear) begin
        cfg_err_reg <= 1'b0;
        err_src_reg <= 1'b0;
        err_dst_reg <= 1'b0;
        pend_reg    <= 1'b0;
        busy_reg    <= 1'b0;
        done_reg    <= 1'b0;
        o_bus_req   <= 1'b0;
        o_bus_valid <= 1'b0;
        state_reg   <= ST_IDLE;
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/dcc_size_step.v
`include "dcc_regs.vh"
`timescale 1ns/100ps
`default_nettype none
// decodes access widths into byte steps, alignment checks and the bandwidth block
module dcc_size_step (
  input  wire [1:0]  i_src_width,
  input  wire [1:0]  i_dst_width,
  input  wire [2:0]  i_interval,
  input  wire [31:0] i_src_addr,
  input  wire [31:0] i_dst_addr,
  input  wire [15:0] i_count,
  output wire [4:0]  o_src_step,
  output wire [4:0]  o_dst_step,
  output wire        o_src_wider,
  output wire        o_cfg_bad,
  output wire [15:0] o_block_mask,
  output wire        o_bw_on
);
  function [4:0] step_of;
    input [1:0] w;
    begin
      case (w)
        `DCC_SZ_BYTE: step_of = 5'h01;
        `DCC_SZ_WORD: step_of = 5'h02;
        `DCC_SZ_LINE: step_of = 5'h10;
        default:      step_of = 5'h04;
      endcase
    end
  endfunction

  // low-bit mask that must be zero for a given width
  function [3:0] low_mask;
    input [1:0] w;
    reg   [4:0] m;
    begin
      m        = step_of(w) - 5'h01;
      low_mask = m[3:0];
    end
  endfunction

  assign o_src_step  = step_of(i_src_width);
  assign o_dst_step  = step_of(i_dst_width);
  assign o_src_wider = (o_src_step >= o_dst_step);
  assign o_cfg_bad = ((i_count[3:0] & low_mask(i_src_width)) != 4'h0)
                  || ((i_count[3:0] & low_mask(i_dst_width)) != 4'h0)
                  || ((i_src_addr[3:0] & low_mask(i_src_width)) != 4'h0)
                  || ((i_dst_addr[3:0] & low_mask(i_dst_width)) != 4'h0);
  assign o_block_mask = (i_interval == 3'h0) ? 16'h0000
                      : ((16'h0200 << (i_interval - 3'h1)) - 16'h0001);
  assign o_bw_on = (i_interval != 3'h0);
endmodule
`default_nettype wire

// ### testbench/dcc_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
module dcc_bus_model (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_req,
  input  wire logic        i_valid,
  input  wire logic [31:0] i_addr,
  input  wire logic        i_slow,
  input  wire logic        i_fail,
  output logic             o_grant,
  output logic             o_ack,
  output logic             o_err,
  output logic      [31:0] o_rdata
);
  logic [1:0] wait_reg;
  // data only meaningful in the answer cycle
  assign o_rdata = o_ack ? i_addr ^ 32'hA5A5_A5A5 : ~(i_addr ^ 32'hA5A5_A5A5);
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_grant <= 1'b0;
      o_ack <= 1'b0;
      o_err <= 1'b0;
      wait_reg <= 2'h0;
    end else begin
      o_grant <= i_req;
      o_ack <= 1'b0;
      o_err <= 1'b0;
      if (i_valid && !o_ack && !o_err) begin
        if (wait_reg == (i_slow ? 2'h3 : 2'h0)) begin
          o_ack <= !i_fail;
          o_err <= i_fail;
          wait_reg <= 2'h0;
        end else begin
          wait_reg <= wait_reg + 2'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/dcc_props.sv
`timescale 1ns/100ps
`default_nettype none
module dcc_props (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic [3:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_bus_valid,
  input wire logic [31:0] o_bus_addr,
  input wire logic        o_bus_rw,
  input wire logic [1:0]  o_bus_size,
  input wire logic        i_bus_ack,
  input wire logic        i_bus_err,
  input wire logic        o_channel_irq_out,
  input wire logic        o_done
);
  logic [15:0] ctl_reg;
  wire         fin = o_bus_valid && i_bus_ack && (!o_bus_rw || ctl_reg[8]);
  // shadow of the control word as software wrote it
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) ctl_reg <= 16'h0000;
    else if (i_wr && i_addr == 4'h2) ctl_reg <= i_wdata[15:0];
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  AST_RD_START: assert property (i_rd && i_addr == 4'h2 |=> !o_rdata[0])
    else $error("start bit read back set");
  AST_DONE_CLEAR: assert property (i_wr && i_addr == 4'h4 && i_wdata[0] |-> ##[1:2] !o_done)
    else $error("done survived clear write");
  AST_IRQ_OFF: assert property (!ctl_reg[15] && !$past(ctl_reg[15]) |-> !o_channel_irq_out)
    else $error("irq while disabled");
  AST_IRQ_CAUSE: assert property (o_channel_irq_out |-> o_done || $past(o_done))
    else $error("irq without completion");
  AST_ONE_RW: assert property (o_bus_valid && ctl_reg[8] |-> o_bus_rw == ctl_reg[7])
    else $error("single access direction wrong");
  AST_SRC_WIDTH: assert property (o_bus_valid && !ctl_reg[8] && !ctl_reg[12] && o_bus_rw
    |-> o_bus_size == ctl_reg[5:4])
    else $error("source width wrong");
  AST_DST_WIDTH: assert property (o_bus_valid && !ctl_reg[8] && !ctl_reg[12] && !o_bus_rw
    |-> o_bus_size == ctl_reg[2:1])
    else $error("destination width wrong");
  AST_STEAL_ONE: assert property (ctl_reg[13] && fin |=> (!o_bus_valid)[*4])
    else $error("second access in cycle steal");
  AST_ADDR_HOLD: assert property (o_bus_valid && !i_bus_ack && !i_bus_err
    && !(i_wr && i_addr == 4'h4 && i_wdata[0])
    |=> o_bus_valid && $stable(o_bus_addr))
    else $error("address moved before answer");
  cover property (o_bus_valid && ctl_reg[8]);
  cover property (ctl_reg[13] && fin);
  cover property ($rose(o_channel_irq_out));
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top;
  typedef struct {logic [15:0] ctl; logic [15:0] cnt; int nacc; logic cfg;} dcc_row_t;
  logic        i_clk, i_rstn, i_wr, i_rd, out_req, grant, ack, err, slow, fail;
  logic        bus_req, valid, rw, irq, done, req_q;
  logic [1:0]  size;
  logic [3:0]  i_addr;
  logic [15:0] cur_ctl;
  logic [31:0] i_wdata, rdata, brdata, baddr, rd_val, last_wa, last_ra, bwdata, last_wd;
  int          fail_count, cmp_count, cycles, naccs, first_fall, i, k, n;
  dcc_row_t rows[9] = '{'{16'h0048, 16'h0008, 2, 0}, '{16'h005A, 16'h0003, 3, 0},
    '{16'h006C, 16'h0004, 2, 0}, '{16'h007E, 16'h0020, 2, 0}, '{16'h006C, 16'h0003, 0, 1},
    '{16'h007E, 16'h0008, 0, 1}, '{16'h0192, 16'h0002, 2, 0}, '{16'h0112, 16'h0002, 2, 0},
    '{16'h8048, 16'h0004, 1, 0}};
  dcc_channel i_dcc_channel (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
    .i_outside_transfer_request(out_req), .o_bus_req(bus_req), .i_bus_grant(grant),
    .o_bus_valid(valid), .o_bus_addr(baddr), .o_bus_rw(rw), .o_bus_size(size),
    .o_bus_wdata(bwdata), .i_bus_rdata(brdata), .i_bus_ack(ack), .i_bus_err(err),
    .o_channel_irq_out(irq), .o_done(done));
  dcc_bus_model i_dcc_bus_model (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(bus_req),
    .i_valid(valid), .i_addr(baddr), .i_slow(slow), .i_fail(fail), .o_grant(grant),
    .o_ack(ack), .o_err(err), .o_rdata(brdata));
  task automatic test_done();
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rd_val = rdata;
  endtask
  task automatic setp(input logic [15:0] c, input logic [15:0] cnt);
    cur_ctl = c;
    naccs = 0;
    wr(4'h0, 32'h0000_1000);
    wr(4'h1, 32'h0000_2000);
    wr(4'h3, {16'h0000, cnt});
    wr(4'h2, {16'h0000, c});
  endtask
  task automatic run(input logic [15:0] c, input logic [15:0] cnt);
    setp(c, cnt);
    wr(4'h2, {16'h0000, c | 16'h0001});
  endtask
  task automatic wait_done();
    for (k = 0; k < 3000 && done !== 1'b1; k++) begin
      @(posedge i_clk);
      #1;
    end
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    req_q <= bus_req;
    if (valid && ack && (!rw || cur_ctl[8])) naccs <= naccs + 1;
    if (valid && ack && !rw) last_wa <= baddr;
    if (valid && ack && !rw) last_wd <= bwdata;
    if (valid && ack && rw) last_ra <= baddr;
    if (req_q && !bus_req && first_fall < 0) first_fall <= naccs;
    if (cycles == 60000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    {i_rstn, i_wr, i_rd, out_req, slow, fail, req_q} = 7'h00;
    {i_addr, i_wdata, cur_ctl} = 52'h0;
    {cycles, naccs, fail_count, cmp_count, first_fall} = {32'd0, 32'd0, 32'd0, 32'd0, -32'd1};
    repeat (5) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd(4'h2);
    `CHK(rd_val, 32'h0000_0000)
    rd(4'h3);
    `CHK(rd_val, 32'h0000_0000)
    rd(4'hF);
    `CHK(rd_val, 32'h0000_0000)
    for (i = 0; i < 9; i++) begin
      slow = i[0];
      run(rows[i].ctl, rows[i].cnt);
      wait_done();
      `CHK(done, 1'b1)
      `CHK(naccs, rows[i].nacc)
      `CHK(irq, rows[i].ctl[15])
      rd(4'h3);
      `CHK(rd_val[15:0], rows[i].cfg ? rows[i].cnt : 16'h0000)
      rd(4'h4);
      `CHK(rd_val[6], rows[i].cfg)
      wr(4'h4, 32'h0000_0001);
    end
    run(16'h2048, 16'h0008);
    for (k = 0; k < 300 && naccs != 1; k++) @(posedge i_clk);
    repeat (20) @(posedge i_clk);
    `CHK(done, 1'b0)
    rd(4'h3);
    `CHK(rd_val[15:0], 16'h0004)
    wr(4'h2, 32'h0000_2049);
    wait_done();
    `CHK(last_wa, 32'h0000_2004)
    `CHK(last_ra, 32'h0000_1004)
    `CHK(last_wd, 32'hA5A5_B5A1)
    wr(4'h4, 32'h0000_0001);
    run(16'h1000, 16'h0008);
    wait_done();
    `CHK(last_ra, 32'h0000_1004)
    `CHK(last_wa, 32'h0000_2000)
    wr(4'h4, 32'h0000_0001);
    setp(16'h2048, 16'h0004);
    out_req <= 1'b1;
    repeat (20) @(posedge i_clk);
    `CHK(naccs, 0)
    out_req <= 1'b0;
    wr(4'h2, 32'h0000_6048);
    out_req <= 1'b1;
    wait_done();
    `CHK(naccs, 1)
    out_req <= 1'b0;
    wr(4'h4, 32'h0000_0001);
    setp(16'h0248, 16'h0204);
    first_fall = -1;
    wr(4'h2, 32'h0000_0249);
    wait_done();
    `CHK(first_fall < 3, 1'b1)
    `CHK(naccs, 129)
    wr(4'h4, 32'h0000_0001);
    slow = 1'b1;
    run(16'h0048, 16'h0040);
    for (k = 0; k < 300 && naccs != 2; k++) @(posedge i_clk);
    wr(4'h4, 32'h0000_0001);
    repeat (8) @(posedge i_clk);
    n = naccs;
    rd(4'h4);
    `CHK(rd_val, 32'h0000_0000)
    repeat (40) @(posedge i_clk);
    `CHK(naccs, n)
    test_done();
  end
endmodule
bind dcc_channel dcc_props i_dcc_props (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_bus_valid(o_bus_valid), .o_bus_addr(o_bus_addr), .o_bus_rw(o_bus_rw),
  .o_bus_size(o_bus_size), .i_bus_ack(i_bus_ack), .i_bus_err(i_bus_err),
  .o_channel_irq_out(o_channel_irq_out), .o_done(o_done));
`default_nettype wire
